// ===== hw/axis_env_pkg.sv
package axis_env_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [3:0] ADDR_ENV5      = 4'h0;
    localparam logic [3:0] ADDR_MAIN_STAT = 4'h1;
    localparam logic [3:0] ADDR_INT_CAUSE = 4'h2;
    localparam logic [3:0] ADDR_ERR_CAUSE = 4'h3;
    localparam logic [3:0] ADDR_COMMAND   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;
    localparam logic [3:0] ADDR_LATCH1    = 4'h8;
    localparam logic [3:0] ADDR_LATCH2    = 4'h9;
    localparam logic [3:0] ADDR_LATCH3    = 4'hA;
    localparam logic [3:0] ADDR_LATCH4    = 4'hB;

    localparam logic [31:0] ENV5_RESET    = 32'h0000_0000;
    localparam logic [31:0] ENV5_WMASK    = 32'h0FFF_F800;

    // ********************************
    // field positions of the environment word
    // ********************************
    localparam int LIMIT_STOP_BIT  = 11;
    localparam int LATCH_TRIG_LSB  = 12;
    localparam int LATCH_SPEED_BIT = 14;
    localparam int HW_LATCH_OFF    = 15;
    localparam int SYNC_OUT_LSB    = 16;
    localparam int SYNC_IN_LSB     = 20;
    localparam int MAIN_HOLD_BIT   = 22;
    localparam int CAUSE_HOLD_BIT  = 23;
    localparam int CLR_ON_LATCH_LSB = 24;

    // ********************************
    // commands
    // ********************************
    localparam logic [7:0] CMD_START       = 8'h01;
    localparam logic [7:0] CMD_SOFT_LATCH  = 8'h02;
    localparam logic [7:0] CMD_CLR_EVENT_A = 8'h2D;
    localparam logic [7:0] CMD_CLR_EVENT_B = 8'h2E;
    localparam logic [7:0] CMD_WR_ERR      = 8'hB2;
    localparam logic [7:0] CMD_WR_INT      = 8'hB3;

    // interrupt status bits
    localparam int IRQ_LIMIT_STOP = 0;
    localparam int IRQ_LATCHED    = 1;
    localparam int IRQ_SYNC       = 2;
    localparam int IRQ_W          = 3;

    // error cause bit for the end-limit stop
    localparam int ERR_LIMIT_BIT  = 0;
    localparam int INT_LATCH_BIT  = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_HALT = 2'b11
    } run_state_t;

    typedef struct packed {
        logic [4:0] cmp_met;
        logic       accel_start;
        logic       accel_end;
        logic       decel_start;
        logic       decel_end;
    } profile_events_t;

    typedef struct packed {
        logic latch;
        logic origin;
        logic limit_pos;
        logic limit_neg;
        logic pulser_drive;
        logic dir_pos;
    } field_inputs_t;

endpackage

// ===== hw/sync_out_select.sv
module sync_out_select (
    input  wire logic                           ref_clk_in,
    input  wire logic                           rst_in,
    input  wire logic [3:0]                     code_in,
    input  wire axis_env_pkg::profile_events_t  events_in,
    output logic                                sync_out
);

    logic sel;

    always_comb begin
        case (code_in)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: sel = events_in.cmp_met[code_in[2:0] - 3'h1];
            4'h8: sel = events_in.accel_start;
            4'h9: sel = events_in.accel_end;
            4'hA: sel = events_in.decel_start;
            4'hB: sel = events_in.decel_end;
            default: sel = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_out <= 1'b0;
        end else begin
            sync_out <= sel;
        end
    end

    a_unassigned_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (!(code_in inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB}))
        |=> !sync_out)
        else $error("sync output active on unassigned code");

    a_cmp_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (code_in == 4'h3 && events_in.cmp_met[2]) |=> sync_out)
        else $error("sync output missed comparator event");

endmodule

// ===== hw/axis_latch_sync_config.sv
module axis_latch_sync_config #(
    parameter int CNT_W = 28
) (
    input  wire logic                           ref_clk_in,
    input  wire logic                           rst_in,
    input  wire logic [3:0]                     addr_in,
    input  wire logic [31:0]                    wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic      [31:0]                    rdata_out,
    input  wire axis_env_pkg::field_inputs_t    field_in,
    input  wire axis_env_pkg::profile_events_t  events_in,
    input  wire logic [3:0]                     axis_sync_in,
    input  wire logic [CNT_W-1:0]               command_position_counter_in,
    input  wire logic [CNT_W-1:0]               mechanical_position_counter_in,
    input  wire logic [CNT_W-1:0]               deflection_counter_in,
    input  wire logic [CNT_W-1:0]               general_purpose_counter_in,
    input  wire logic [CNT_W-1:0]               speed_in,
    input  wire logic                           event_a_in,
    input  wire logic                           event_b_in,
    input  wire logic [7:0]                     int_cause_set_in,
    input  wire logic [7:0]                     err_cause_set_in,
    output logic [3:0]                          counter_clear_out,
    output logic                                sync_out,
    output logic                                run_out,
    output logic                                irq_out
);

    // ********************************
    // environment register and commands
    // ********************************
    logic [31:0] env_r;
    logic        cmd_wr;
    logic [7:0]  cmd;

    assign cmd_wr = wr_in && addr_in == axis_env_pkg::ADDR_COMMAND;
    assign cmd    = wdata_in[7:0];

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            env_r <= axis_env_pkg::ENV5_RESET;
        end else if (wr_in && addr_in == axis_env_pkg::ADDR_ENV5) begin
            env_r <= wdata_in & axis_env_pkg::ENV5_WMASK;
        end
    end

    logic [1:0] trig_sel;
    logic [3:0] sync_sel;
    logic [1:0] sync_src;
    logic [3:0] clr_on_latch;
    logic       main_hold;
    logic       cause_hold;

    assign trig_sel     = env_r[axis_env_pkg::LATCH_TRIG_LSB +: 2];
    assign sync_sel     = env_r[axis_env_pkg::SYNC_OUT_LSB +: 4];
    assign sync_src     = env_r[axis_env_pkg::SYNC_IN_LSB +: 2];
    assign clr_on_latch = env_r[axis_env_pkg::CLR_ON_LATCH_LSB +: 4];
    assign main_hold    = env_r[axis_env_pkg::MAIN_HOLD_BIT];
    assign cause_hold   = env_r[axis_env_pkg::CAUSE_HOLD_BIT];

    // ********************************
    // latch trigger
    // ********************************
    logic       hw_trig;
    logic       latch_fire;
    logic       soft_latch;
    logic       latch_in_d_r;
    logic       origin_d_r;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_in_d_r <= 1'b0;
            origin_d_r   <= 1'b0;
        end else begin
            latch_in_d_r <= field_in.latch;
            origin_d_r   <= field_in.origin;
        end
    end

    always_comb begin
        case (trig_sel)
            2'b00:   hw_trig = field_in.latch && !latch_in_d_r;
            2'b01:   hw_trig = field_in.origin && !origin_d_r;
            2'b10:   hw_trig = events_in.cmp_met[3];
            2'b11:   hw_trig = events_in.cmp_met[4];
            default: hw_trig = 1'b0;
        endcase
    end

    assign soft_latch = cmd_wr && cmd == axis_env_pkg::CMD_SOFT_LATCH;
    assign latch_fire = soft_latch || (hw_trig && !env_r[axis_env_pkg::HW_LATCH_OFF]);

    // ********************************
    // latched values
    // ********************************
    logic [CNT_W-1:0] latch_r [4];
    logic [CNT_W-1:0] capture [4];

    assign capture[0] = command_position_counter_in;
    assign capture[1] = mechanical_position_counter_in;
    assign capture[2] = env_r[axis_env_pkg::LATCH_SPEED_BIT] ? speed_in : deflection_counter_in;
    assign capture[3] = general_purpose_counter_in;

    // all four slots load on the same edge so software sees one coherent snapshot
    for (genvar i = 0; i < 4; i++) begin : g_latch
        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                latch_r[i] <= '0;
            end else if (latch_fire) begin
                latch_r[i] <= capture[i];
            end
        end
        assign counter_clear_out[i] = latch_fire && clr_on_latch[i];
    end

    // ********************************
    // sync output and sync start
    // ********************************
    sync_out_select u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .code_in    (sync_sel),
        .events_in  (events_in),
        .sync_out   (sync_out)
    );

    logic sync_start;
    assign sync_start = axis_sync_in[sync_src];

    // ********************************
    // run control with end-limit stop
    // ********************************
    axis_env_pkg::run_state_t state_r;
    logic limit_hit;
    logic cmd_start;

    assign cmd_start = cmd_wr && cmd == axis_env_pkg::CMD_START;
    assign limit_hit = env_r[axis_env_pkg::LIMIT_STOP_BIT] && field_in.pulser_drive
                       && (field_in.dir_pos ? field_in.limit_pos : field_in.limit_neg);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= axis_env_pkg::ST_IDLE;
        end else begin
            case (state_r)
                axis_env_pkg::ST_IDLE: begin
                    if (cmd_start || sync_start) begin
                        state_r <= axis_env_pkg::ST_RUN;
                    end
                end
                axis_env_pkg::ST_RUN: begin
                    if (limit_hit) begin
                        state_r <= axis_env_pkg::ST_HALT;
                    end
                end
                axis_env_pkg::ST_HALT: begin
                    // sync start alone must not restart after a limit stop
                    if (cmd_start) begin
                        state_r <= axis_env_pkg::ST_RUN;
                    end
                end
                default: state_r <= axis_env_pkg::ST_IDLE;
            endcase
        end
    end

    assign run_out = state_r == axis_env_pkg::ST_RUN;

    // ********************************
    // status flags
    // ********************************
    logic [1:0] main_flags_r;
    logic [7:0] int_cause_r;
    logic [7:0] err_cause_r;
    logic       rd_main;
    logic       rd_int;
    logic       rd_err;
    logic       limit_evt;

    assign rd_main   = rd_in && addr_in == axis_env_pkg::ADDR_MAIN_STAT;
    assign rd_int    = rd_in && addr_in == axis_env_pkg::ADDR_INT_CAUSE;
    assign rd_err    = rd_in && addr_in == axis_env_pkg::ADDR_ERR_CAUSE;
    assign limit_evt = state_r == axis_env_pkg::ST_RUN && limit_hit;

    // set wins over every clear below
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            main_flags_r <= 2'h0;
        end else begin
            main_flags_r <= (main_flags_r
                & ~{2{rd_main && !main_hold}}
                & ~{cmd_wr && cmd == axis_env_pkg::CMD_CLR_EVENT_B,
                    cmd_wr && cmd == axis_env_pkg::CMD_CLR_EVENT_A})
                | {event_b_in, event_a_in};
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_cause_r <= 8'h00;
            err_cause_r <= 8'h00;
        end else begin
            int_cause_r <= (int_cause_r
                & ~{8{rd_int && !cause_hold}}
                & ~((cmd_wr && cmd == axis_env_pkg::CMD_WR_INT) ? wdata_in[15:8] : 8'h00))
                | int_cause_set_in | {7'h00, latch_fire};
            err_cause_r <= (err_cause_r
                & ~{8{rd_err && !cause_hold}}
                & ~((cmd_wr && cmd == axis_env_pkg::CMD_WR_ERR) ? wdata_in[15:8] : 8'h00))
                | err_cause_set_in | {7'h00, limit_evt};
        end
    end

    // ********************************
    // interrupt status and mask
    // ********************************
    logic [axis_env_pkg::IRQ_W-1:0] irq_stat_r;
    logic [axis_env_pkg::IRQ_W-1:0] irq_mask_r;
    logic [axis_env_pkg::IRQ_W-1:0] irq_set;
    logic                           sync_d_r;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_out;
        end
    end

    assign irq_set = {sync_out && !sync_d_r, latch_fire, limit_evt};

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_in && addr_in == axis_env_pkg::ADDR_IRQ_STAT)
                ? wdata_in[axis_env_pkg::IRQ_W-1:0] : '0)) | irq_set;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_r <= '0;
        end else if (wr_in && addr_in == axis_env_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= wdata_in[axis_env_pkg::IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ********************************
    // read data, one cycle after the strobe
    // ********************************
    logic [31:0] rd_mux;

    always_comb begin
        case (addr_in)
            axis_env_pkg::ADDR_ENV5:      rd_mux = env_r;
            axis_env_pkg::ADDR_MAIN_STAT: rd_mux = {28'h0, run_out, state_r == axis_env_pkg::ST_HALT,
                                                    main_flags_r};
            axis_env_pkg::ADDR_INT_CAUSE: rd_mux = {24'h0, int_cause_r};
            axis_env_pkg::ADDR_ERR_CAUSE: rd_mux = {24'h0, err_cause_r};
            axis_env_pkg::ADDR_IRQ_STAT:  rd_mux = {29'h0, irq_stat_r};
            axis_env_pkg::ADDR_IRQ_MASK:  rd_mux = {29'h0, irq_mask_r};
            axis_env_pkg::ADDR_LATCH1:    rd_mux = 32'(latch_r[0]);
            axis_env_pkg::ADDR_LATCH2:    rd_mux = 32'(latch_r[1]);
            axis_env_pkg::ADDR_LATCH3:    rd_mux = 32'(latch_r[2]);
            axis_env_pkg::ADDR_LATCH4:    rd_mux = 32'(latch_r[3]);
            default:                      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            rdata_out <= rd_mux;
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // ********************************
    // checks
    // ********************************
    a_hw_latch_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (env_r[axis_env_pkg::HW_LATCH_OFF] && !soft_latch) |-> !latch_fire)
        else $error("hardware latch taken while disabled");

    a_latch_slot3: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (latch_fire && env_r[axis_env_pkg::LATCH_SPEED_BIT]) |=> latch_r[2] == $past(speed_in))
        else $error("speed not latched into deflection slot");

    a_latch_all: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        latch_fire |=> latch_r[0] == $past(command_position_counter_in) && latch_r[3] == $past(general_purpose_counter_in))
        else $error("counters not latched together");

    a_clear_same: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        counter_clear_out[1] |-> latch_fire && clr_on_latch[1])
        else $error("counter cleared outside a latch");

    a_trig_origin: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (trig_sel == 2'b01 && !env_r[axis_env_pkg::HW_LATCH_OFF] && $rose(field_in.origin))
        |-> latch_fire)
        else $error("origin edge did not latch");

    a_limit_halt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (state_r == axis_env_pkg::ST_RUN && limit_hit) |=>
        state_r == axis_env_pkg::ST_HALT && err_cause_r[axis_env_pkg::ERR_LIMIT_BIT])
        else $error("limit did not stop the axis");

    a_halt_needs_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (state_r == axis_env_pkg::ST_HALT && !cmd_start) |=> state_r == axis_env_pkg::ST_HALT)
        else $error("axis left limit stop without start");

    a_main_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_main && main_hold && main_flags_r[0] && !cmd_wr) |=> main_flags_r[0])
        else $error("held main flag cleared by read");

    a_cause_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_int && !cause_hold && int_cause_set_in == 8'h00 && !latch_fire) |=> int_cause_r == 8'h00)
        else $error("cause register not cleared on read");

endmodule

// ===== test/field_model.sv
module field_model #(
    parameter int CNT_W = 28
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [3:0]       clear_in,
    output logic      [CNT_W-1:0] cnt1_out,
    output logic      [CNT_W-1:0] cnt2_out,
    output logic      [CNT_W-1:0] cnt3_out,
    output logic      [CNT_W-1:0] cnt4_out,
    output logic      [CNT_W-1:0] speed_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [CNT_W-1:0] cnt_r [4];

    // ********************************
    // counters owned by the drive side
    // ********************************
    // each counter steps by a different odd amount so a swapped slot shows up
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) cnt_r[i] <= CNT_W'(32'h100 * (i + 1));
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= clear_in[i] ? '0 : cnt_r[i] + CNT_W'(2 * i + 1);
            end
        end
    end

    assign cnt1_out = cnt_r[0];
    assign cnt2_out = cnt_r[1];
    assign cnt3_out = cnt_r[2];
    assign cnt4_out = cnt_r[3];
    assign speed_out = cnt_r[0] + CNT_W'(28'h0ABC);
endmodule

// ===== test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CNT_W = 28;
    logic                          ref_clk_in = 1'b0;
    logic                          rst_in     = 1'b1;
    logic [3:0]                    addr       = 4'h0;
    logic [31:0]                   wdata      = 32'h0;
    logic                          wr         = 1'b0;
    logic                          rd         = 1'b0;
    axis_env_pkg::field_inputs_t   fld        = '0;
    axis_env_pkg::profile_events_t ev         = '0;
    logic [3:0]                    axs        = 4'h0;
    logic                          ev_a       = 1'b0;
    logic                          ev_b       = 1'b0;
    logic [7:0]                    iset       = 8'h00;
    logic [7:0]                    eset       = 8'h00;
    logic [31:0]                   lfsr_r     = 32'h8811;
    logic [31:0]                   rdata, m_env, m_slot [4];
    logic [CNT_W-1:0]              c1, c2, c3, c4, spd;
    logic [3:0]                    clr;
    logic                          sync, run, irq, irq_a;
    int                            n_fail = 0, num_checks = 0, m_ic, m_ec, msk;

`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end

    always #50 ref_clk_in = ~ref_clk_in;

    axis_latch_sync_config #(.CNT_W(CNT_W)) i_axis_latch_sync_config (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .field_in(fld), .events_in(ev),
        .axis_sync_in(axs), .command_position_counter_in(c1), .mechanical_position_counter_in(c2), .deflection_counter_in(c3),
        .general_purpose_counter_in(c4), .speed_in(spd), .event_a_in(ev_a), .event_b_in(ev_b),
        .int_cause_set_in(iset), .err_cause_set_in(eset), .counter_clear_out(clr),
        .sync_out(sync), .run_out(run), .irq_out(irq));

    field_model #(.CNT_W(CNT_W)) i_field_model (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clear_in(clr), .cnt1_out(c1),
        .cnt2_out(c2), .cnt3_out(c3), .cnt4_out(c4), .speed_out(spd));

    // ********************************
    // bus tasks and model
    // ********************************
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp, "register read")
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] m);
        wr_reg(axis_env_pkg::ADDR_COMMAND, {16'h0, m, c});
    endtask

    task automatic do_reset();
        rst_in <= 1'b1;
        axs <= 4'h0;
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        m_env = axis_env_pkg::ENV5_RESET;
        m_ic = 0;
        for (int i = 0; i < 4; i++) m_slot[i] = 32'h0;
    endtask

    // k 0..3 fires a hardware trigger, 4 the software latch command
    task automatic fire_latch(input int k, input logic hit);
        @(posedge ref_clk_in);
        case (k)
            0: fld.latch <= 1'b1;
            1: fld.origin <= 1'b1;
            2: ev.cmp_met[3] <= 1'b1;
            3: ev.cmp_met[4] <= 1'b1;
            default: begin
                addr <= axis_env_pkg::ADDR_COMMAND;
                wdata <= 32'(axis_env_pkg::CMD_SOFT_LATCH);
                wr <= 1'b1;
            end
        endcase
        #1;
        `CHK(clr, hit ? m_env[27:24] : 4'h0, "clear on latch")
        if (hit) begin
            m_slot[0] = 32'(c1);
            m_slot[1] = 32'(c2);
            m_slot[2] = m_env[14] ? 32'(spd) : 32'(c3);
            m_slot[3] = 32'(c4);
        end
        @(posedge ref_clk_in);
        fld <= '0;
        ev <= '0;
        wr <= 1'b0;
        for (int i = 0; i < 4; i++) chk_reg(4'(axis_env_pkg::ADDR_LATCH1 + i), m_slot[i]);
    endtask

    function automatic int sync_bit(input int code);
        if (code >= 1 && code <= 5) return code + 3;
        if (code >= 8 && code <= 11) return 11 - code;
        return -1;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk_in);
        n_fail++;
        tally_and_finish();
    end

    // ********************************
    // scenarios
    // ********************************
    initial begin
        do_reset();
        chk_reg(axis_env_pkg::ADDR_ENV5, axis_env_pkg::ENV5_RESET);
        wr_reg(axis_env_pkg::ADDR_ENV5, 32'hFFFF_FFFF);
        wr_reg(4'h7, 32'h0);
        chk_reg(axis_env_pkg::ADDR_ENV5, axis_env_pkg::ENV5_WMASK);
        chk_reg(4'h7, 32'h0);
        for (int k = 0; k < 4; k++) begin
            m_env = (rnd() & 32'h0F00_4000) | (k << 12);
            wr_reg(axis_env_pkg::ADDR_ENV5, m_env);
            fire_latch((k + 1) % 4, 1'b0);
            fire_latch(k, 1'b1);
        end
        m_env = 32'h0F00_C000;
        wr_reg(axis_env_pkg::ADDR_ENV5, m_env);
        fire_latch(0, 1'b0);
        fire_latch(4, 1'b1);
        wr_reg(axis_env_pkg::ADDR_IRQ_MASK, 32'h0);
        #1 irq_a = irq;
        wr_reg(axis_env_pkg::ADDR_IRQ_MASK, 32'h7);
        #1 `CHK(irq ^ irq_a, 1'b1, "mask changes irq")
        chk_reg(axis_env_pkg::ADDR_IRQ_MASK, 32'h7);
        chk_reg(axis_env_pkg::ADDR_IRQ_STAT, 32'h2);
        wr_reg(axis_env_pkg::ADDR_IRQ_STAT, 32'h2);
        #1 `CHK(irq, 1'b0, "irq after clear")
        chk_reg(axis_env_pkg::ADDR_IRQ_STAT, 32'h0);
        for (int code = 0; code < 16; code++) begin
            wr_reg(axis_env_pkg::ADDR_ENV5, code << 16);
            for (int e = 0; e < 9; e++) begin
                @(posedge ref_clk_in);
                ev <= 9'(1) << e;
                @(posedge ref_clk_in);
                ev <= '0;
                #1 `CHK(sync, 1'(e == sync_bit(code)), "sync output")
            end
        end
        chk_reg(axis_env_pkg::ADDR_IRQ_STAT, 32'h4);
        for (int k = 0; k < 4; k++) begin
            do_reset();
            wr_reg(axis_env_pkg::ADDR_ENV5, (k << 20) | 32'h800);
            @(posedge ref_clk_in);
            axs <= 4'hF ^ (4'h1 << k);
            fld.pulser_drive <= 1'b1;
            fld.dir_pos <= k[0];
            fld.limit_pos <= ~k[0];
            fld.limit_neg <= k[0];
            repeat (3) @(posedge ref_clk_in);
            axs <= 4'h1 << k;
            #1 `CHK(run, 1'b0, "other axis ignored")
            @(posedge ref_clk_in);
            axs <= 4'h0;
            #1 `CHK(run, 1'b1, "sync start")
            repeat (3) @(posedge ref_clk_in);
            fld.limit_pos <= k[0];
            fld.limit_neg <= ~k[0];
            #1 `CHK(run, 1'b1, "opposite limit ignored")
            repeat (2) @(posedge ref_clk_in);
            #1 `CHK(run, 1'b0, "limit halt")
            fld <= '0;
            // sync start held high while halted must not restart the axis
            axs <= 4'h1 << k;
            chk_reg(axis_env_pkg::ADDR_MAIN_STAT, 32'h4);
            chk_reg(axis_env_pkg::ADDR_ERR_CAUSE, 32'h1);
            chk_reg(axis_env_pkg::ADDR_IRQ_STAT, 32'h1);
            cmd(axis_env_pkg::CMD_START, 8'h00);
            #1 `CHK(run, 1'b1, "restart by command")
        end
        for (int h = 0; h < 2; h++) begin
            do_reset();
            wr_reg(axis_env_pkg::ADDR_ENV5, h ? 32'h00C0_0000 : 32'h0);
            m_ic = (rnd() & 32'hFE) | 32'h10;
            m_ec = (rnd() & 32'hFF) | 32'h04;
            @(posedge ref_clk_in);
            {ev_a, ev_b, iset, eset} <= {2'b11, 8'(m_ic), 8'(m_ec)};
            @(posedge ref_clk_in);
            {ev_a, ev_b, iset, eset} <= '0;
            chk_reg(axis_env_pkg::ADDR_MAIN_STAT, 32'h3);
            chk_reg(axis_env_pkg::ADDR_MAIN_STAT, h ? 32'h3 : 32'h0);
            chk_reg(axis_env_pkg::ADDR_INT_CAUSE, m_ic);
            chk_reg(axis_env_pkg::ADDR_INT_CAUSE, h ? m_ic : 0);
            chk_reg(axis_env_pkg::ADDR_ERR_CAUSE, m_ec);
            chk_reg(axis_env_pkg::ADDR_ERR_CAUSE, h ? m_ec : 0);
            if (h == 1) begin
                cmd(axis_env_pkg::CMD_CLR_EVENT_A, 8'h00);
                chk_reg(axis_env_pkg::ADDR_MAIN_STAT, 32'h2);
                cmd(axis_env_pkg::CMD_CLR_EVENT_B, 8'h00);
                chk_reg(axis_env_pkg::ADDR_MAIN_STAT, 32'h0);
                msk = (rnd() & 32'hEF) | 32'h80;
                cmd(axis_env_pkg::CMD_WR_INT, 8'(msk));
                chk_reg(axis_env_pkg::ADDR_INT_CAUSE, m_ic & ~msk & 32'hFF);
                cmd(axis_env_pkg::CMD_WR_ERR, 8'(msk));
                chk_reg(axis_env_pkg::ADDR_ERR_CAUSE, m_ec & ~msk & 32'hFF);
            end
        end
        tally_and_finish();
    end
endmodule
